// ==== common/afe_cfg_pkg.sv ====
package afe_cfg_pkg;

  // register offsets
  localparam logic [15:0] OFS_TEMP_EXPORT   = 16'h18E6;
  localparam logic [15:0] OFS_COUPLING      = 16'h1908;
  localparam logic [15:0] OFS_FULL_SCALE    = 16'h1910;
  localparam logic [15:0] OFS_BUF_CUR_P     = 16'h1A4C;
  localparam logic [15:0] OFS_BUF_CUR_N     = 16'h1A4D;

  // reset values
  localparam logic [7:0]  RST_TEMP_EXPORT   = 8'h00;
  localparam logic [7:0]  RST_COUPLING      = 8'h00;
  localparam logic [7:0]  RST_FULL_SCALE    = 8'h0D;
  localparam logic [7:0]  RST_BUF_CUR       = 8'h1E;

  // field layout
  localparam int          DC_COUPLE_BIT     = 2;
  localparam int          FS_WIDTH          = 4;
  localparam int          BUF_CUR_WIDTH     = 6;
  localparam int          DIODE_CORE_BIT    = 6;

  // reference pin modes
  typedef enum logic [1:0] {
    REFPIN_HIGHZ,
    REFPIN_UNITY,
    REFPIN_X20,
    REFPIN_GND
  } refpin_mode_t;

  // decoded temperature export
  typedef struct packed {
    logic         core_diode;
    refpin_mode_t pin_mode;
    logic         code_valid;
  } temp_export_t;

  // full-scale range in millivolts peak-to-peak
  localparam logic [11:0] FS_MV_CODE_0      = 12'h7F8;
  localparam logic [11:0] FS_MV_CODE_A      = 12'h550;
  localparam logic [11:0] FS_MV_CODE_B      = 12'h5BE;
  localparam logic [11:0] FS_MV_CODE_C      = 12'h636;
  localparam logic [11:0] FS_MV_CODE_D      = 12'h6A4;
  localparam logic [11:0] FS_MV_CODE_E      = 12'h712;
  localparam logic [11:0] FS_MV_CODE_F      = 12'h78A;

  // buffer current mapping: 120 uA at code 6, 20 uA per code
  localparam logic [5:0]  BUF_CODE_MIN      = 6'h06;
  localparam logic [5:0]  BUF_CODE_MAX      = 6'h14;
  localparam logic [9:0]  BUF_UA_MIN        = 10'h078;
  localparam logic [9:0]  BUF_UA_PER_CODE   = 10'h014;

  // analog control bundle
  typedef struct packed {
    temp_export_t temp;
    logic         dc_coupled;
    logic [3:0]   full_scale_trim;
    logic [11:0]  full_scale_mv;
    logic         fs_valid;
  } afe_ctrl_t;

endpackage

// ==== design/temp_export_decode.sv ====
module temp_export_decode
  import afe_cfg_pkg::*;
(
  // selection code
  input  wire logic [7:0]   code,
  // decoded control
  output temp_export_t      sel
);

  wire logic known_code;

  assign known_code = (code[7] == 1'b0) && (code[5:2] == 4'h0);
  // bit 6 picks core diode, low bits pick pin mode
  assign sel.core_diode = code[DIODE_CORE_BIT];
  assign sel.pin_mode   = known_code ? refpin_mode_t'(code[1:0]) : REFPIN_HIGHZ;
  assign sel.code_valid = known_code;

endmodule // temp_export_decode

// ==== design/buffer_current_decode.sv ====
module buffer_current_decode
  import afe_cfg_pkg::*;
#(
  parameter int WIDTH = BUF_CUR_WIDTH
) (
  // current code
  input  wire logic [WIDTH-1:0] code,
  // current in microamps
  output logic      [9:0]       micro_amps,
  output logic                  in_range
);

  wire logic [9:0] offset_codes;

  assign in_range     = (code >= WIDTH'(BUF_CODE_MIN)) && (code <= WIDTH'(BUF_CODE_MAX))
                        && (code[0] == 1'b0);
  assign offset_codes = 10'(code) - 10'(BUF_CODE_MIN);
  assign micro_amps   = in_range ? 10'(BUF_UA_MIN + offset_codes * BUF_UA_PER_CODE)
                                 : 10'h000;

endmodule // buffer_current_decode

// ==== design/analog_front_end_config_regs.sv ====
// Notes on behaviour
// - code 0x00 selects central diode, reference pin high impedance; all 8 bits code.
// - central diode codes 0x01 unity, 0x02 twentyfold, 0x03 pin grounded.
// - 0x40 core diode high impedance; 0x41 unity, 0x42 twentyfold.
// - 0x43 selects core diode with reference pin grounded.
// - export select is read/write and resets to zero.
// - coupling bit 2 set means dc optimised, clear ac; resets zero.
// - four-bit full-scale field resets to 0xD, 1.70 V range.
// - full-scale code zero selects 2.04 V, the largest range.
// - codes 1010, 1011, 1110, 1111 give 1.36, 1.47, 1.81, 1.93 V.
// - full-scale code 1100 gives 1.59 V.
// - positive buffer current is six-bit field resetting 0x1E, top bits reserved.
// - negative buffer current identical six-bit field resetting 0x1E.
// - current codes 00110 is 120 uA, 20 uA per code, to 10100 at 400 uA; odd codes and codes outside that range give 0 uA.
module analog_front_end_config_regs
  import afe_cfg_pkg::*;
#(
  parameter int ADDR_WIDTH = 16
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // register port
  input  wire logic [ADDR_WIDTH-1:0] addr,
  input  wire logic [7:0]            wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [7:0]            rdata,
  output logic                       addr_err,
  // analog controls
  output afe_ctrl_t                  afe_ctrl,
  output logic      [BUF_CUR_WIDTH-1:0] buf_cur_p,
  output logic      [BUF_CUR_WIDTH-1:0] buf_cur_n,
  output logic      [9:0]            buf_ua_p,
  output logic      [9:0]            buf_ua_n
);

  // stored fields
  logic [7:0]               temp_export_select;
  logic                     dc_coupling;
  logic [FS_WIDTH-1:0]      full_scale_trim;
  logic [BUF_CUR_WIDTH-1:0] cur_p;
  logic [BUF_CUR_WIDTH-1:0] cur_n;

  // decode
  wire logic       hit_temp;
  wire logic       hit_coup;
  wire logic       hit_fs;
  wire logic       hit_p;
  wire logic       hit_n;
  wire logic       hit_any;
  wire logic [7:0] read_mux;
  wire logic [7:0] next_rdata;

  function automatic logic match(input logic [ADDR_WIDTH-1:0] a, input logic [15:0] ofs);
    match = (a == ADDR_WIDTH'(ofs));
  endfunction

  assign hit_temp = match(addr, OFS_TEMP_EXPORT);
  assign hit_coup = match(addr, OFS_COUPLING);
  assign hit_fs   = match(addr, OFS_FULL_SCALE);
  assign hit_p    = match(addr, OFS_BUF_CUR_P);
  assign hit_n    = match(addr, OFS_BUF_CUR_N);
  assign hit_any  = hit_temp | hit_coup | hit_fs | hit_p | hit_n;

  // read data with reserved bits as zero
  assign read_mux =
      hit_temp ? temp_export_select :
      hit_coup ? {5'h00, dc_coupling, 2'h0} :
      hit_fs   ? {4'h0, full_scale_trim} :
      hit_p    ? {2'h0, cur_p} :
      hit_n    ? {2'h0, cur_n} :
                 8'h00;
  assign next_rdata = rd ? read_mux : 8'h00;

  // register writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      temp_export_select <= RST_TEMP_EXPORT;
      dc_coupling        <= RST_COUPLING[DC_COUPLE_BIT];
      full_scale_trim    <= RST_FULL_SCALE[FS_WIDTH-1:0];
      cur_p              <= RST_BUF_CUR[BUF_CUR_WIDTH-1:0];
      cur_n              <= RST_BUF_CUR[BUF_CUR_WIDTH-1:0];
    end else if (wr) begin
      if (hit_temp) begin
        temp_export_select <= wdata;
      end
      if (hit_coup) begin
        dc_coupling <= wdata[DC_COUPLE_BIT];
      end
      if (hit_fs) begin
        full_scale_trim <= wdata[FS_WIDTH-1:0];
      end
      if (hit_p) begin
        cur_p <= wdata[BUF_CUR_WIDTH-1:0];
      end
      if (hit_n) begin
        cur_n <= wdata[BUF_CUR_WIDTH-1:0];
      end
    end
  end

  // read data one cycle later
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata    <= 8'h00;
      addr_err <= 1'b0;
    end else begin
      rdata    <= next_rdata;
      addr_err <= (rd | wr) & ~hit_any;
    end
  end

  // full-scale range lookup
  logic [11:0] fs_mv;
  logic        fs_ok;

  always_comb begin
    fs_ok = 1'b1;
    case (full_scale_trim)
      4'h0:    fs_mv = FS_MV_CODE_0;
      4'hA:    fs_mv = FS_MV_CODE_A;
      4'hB:    fs_mv = FS_MV_CODE_B;
      4'hC:    fs_mv = FS_MV_CODE_C;
      4'hD:    fs_mv = FS_MV_CODE_D;
      4'hE:    fs_mv = FS_MV_CODE_E;
      4'hF:    fs_mv = FS_MV_CODE_F;
      default: begin
        fs_mv = FS_MV_CODE_D;
        fs_ok = 1'b0;
      end
    endcase
  end

  // decoders
  temp_export_t temp_sel;

  temp_export_decode u_temp (
    .code (temp_export_select),
    .sel  (temp_sel)
  );

  buffer_current_decode #(.WIDTH(BUF_CUR_WIDTH)) u_cur_p (
    .code       (cur_p),
    .micro_amps (buf_ua_p),
    .in_range   ()
  );

  buffer_current_decode #(.WIDTH(BUF_CUR_WIDTH)) u_cur_n (
    .code       (cur_n),
    .micro_amps (buf_ua_n),
    .in_range   ()
  );

  // analog outputs
  assign afe_ctrl.temp            = temp_sel;
  assign afe_ctrl.dc_coupled      = dc_coupling;
  assign afe_ctrl.full_scale_trim = full_scale_trim;
  assign afe_ctrl.full_scale_mv   = fs_mv;
  assign afe_ctrl.fs_valid        = fs_ok;
  assign buf_cur_p                = cur_p;
  assign buf_cur_n                = cur_n;

endmodule // analog_front_end_config_regs

// ==== tb/analog_front_end_config_regs_asserts.sv ====
module analog_front_end_config_regs_asserts
  import afe_cfg_pkg::*;
#(
  parameter int ADDR_WIDTH = 16
) (
  // watched ports
  input wire logic                     clk,
  input wire logic                     nrst,
  input wire logic [ADDR_WIDTH-1:0]    addr,
  input wire logic [7:0]               wdata,
  input wire logic                     wr,
  input wire logic                     rd,
  input wire logic [7:0]               rdata,
  input wire logic                     addr_err,
  input wire afe_ctrl_t                afe_ctrl,
  input wire logic [BUF_CUR_WIDTH-1:0] buf_cur_p,
  input wire logic [BUF_CUR_WIDTH-1:0] buf_cur_n,
  input wire logic [9:0]               buf_ua_p,
  input wire logic [9:0]               buf_ua_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_temp;
    wr && addr == 16'h18E6 && (wdata & 8'hBC) == 8'h00 |=>
      afe_ctrl.temp.core_diode == $past(wdata[6]) && afe_ctrl.temp.pin_mode == $past(wdata[1:0]);
  endproperty
  a_temp: assert property (p_temp) else $error("temp decode wrong");
  property p_dc;
    wr && addr == 16'h1908 |=> afe_ctrl.dc_coupled == $past(wdata[2]);
  endproperty
  a_dc: assert property (p_dc) else $error("coupling wrong");
  property p_trim;
    wr && addr == 16'h1910 ##1 !wr |-> afe_ctrl.full_scale_trim == $past(wdata[3:0]);
  endproperty
  a_trim: assert property (p_trim) else $error("trim wrong");
  property p_fs0;
    afe_ctrl.full_scale_trim == 4'h0 |-> afe_ctrl.full_scale_mv == 12'h7F8;
  endproperty
  a_fs0: assert property (p_fs0) else $error("range 0 wrong");
  property p_fsc;
    afe_ctrl.full_scale_trim == 4'hC |-> afe_ctrl.full_scale_mv == 12'h636;
  endproperty
  a_fsc: assert property (p_fsc) else $error("range C wrong");
  property p_ua;
    buf_cur_p >= 6'h06 && buf_cur_p <= 6'h14 && !buf_cur_p[0] |->
      buf_ua_p == 10'h078 + 10'h014 * 10'(buf_cur_p - 6'h06);
  endproperty
  a_ua: assert property (p_ua) else $error("current wrong");
  property p_bufn;
    wr && addr == 16'h1A4D |=> buf_cur_n == $past(wdata[5:0]);
  endproperty
  a_bufn: assert property (p_bufn) else $error("neg current wrong");
  property p_rdfs;
    rd && addr == 16'h1910 |=> rdata == {4'h0, $past(afe_ctrl.full_scale_trim)};
  endproperty
  a_rdfs: assert property (p_rdfs) else $error("read wrong");
  property p_rst;
    $rose(nrst) |-> buf_cur_p == 6'h1E && buf_cur_n == 6'h1E && !afe_ctrl.dc_coupled
      && afe_ctrl.full_scale_trim == 4'hD && afe_ctrl.temp.pin_mode == REFPIN_HIGHZ;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  c_gnd: cover property (afe_ctrl.temp.core_diode && afe_ctrl.temp.pin_mode == REFPIN_GND);
  c_fs0: cover property (afe_ctrl.full_scale_trim == 4'h0);
  c_ua: cover property (buf_ua_p == 10'h190);
endmodule // analog_front_end_config_regs_asserts

bind analog_front_end_config_regs analog_front_end_config_regs_asserts #(
  .ADDR_WIDTH(ADDR_WIDTH)) chk_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .addr_err(addr_err), .afe_ctrl(afe_ctrl),
  .buf_cur_p(buf_cur_p), .buf_cur_n(buf_cur_n), .buf_ua_p(buf_ua_p), .buf_ua_n(buf_ua_n));

// ==== tb/analog_front_end_config_regs_test.sv ====
module analog_front_end_config_regs_test
  import afe_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [15:0] a;
    logic [7:0]  d;
    logic [7:0]  r;
    logic        e;
  } row_t;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic        addr_err;
  afe_ctrl_t   afe_ctrl;
  logic [5:0]  buf_cur_p;
  logic [5:0]  buf_cur_n;
  logic [9:0]  buf_ua_p;
  logic [9:0]  buf_ua_n;
  logic [7:0]  got;
  int          fail_count = 0;
  int          compares = 0;
  row_t        rows [6] = '{'{16'h18E6, 8'h43, 8'h43, 1'b0}, '{16'h1908, 8'hFF, 8'h04, 1'b0},
    '{16'h1910, 8'hFA, 8'h0A, 1'b0}, '{16'h1A4C, 8'hD4, 8'h14, 1'b0},
    '{16'h1A4D, 8'hC6, 8'h06, 1'b0}, '{16'h1A4E, 8'hFF, 8'h00, 1'b1}};
  logic [3:0]  fs_code [7] = '{4'h0, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
  logic [11:0] fs_mv [7] = '{12'h7F8, 12'h550, 12'h5BE, 12'h636, 12'h6A4, 12'h712, 12'h78A};

  always #25 clk = ~clk;

  analog_front_end_config_regs dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .addr_err(addr_err), .afe_ctrl(afe_ctrl),
    .buf_cur_p(buf_cur_p), .buf_cur_n(buf_cur_n), .buf_ua_p(buf_ua_p), .buf_ua_n(buf_ua_n));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic results;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, got);
      chk("readback", rows[i].r, got);
      chk("addr_err", 16'(rows[i].e), addr_err);
    end
    $display("test rows done");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("trim", 16'hD, afe_ctrl.full_scale_trim);
    chk("mv", 16'h6A4, afe_ctrl.full_scale_mv);
    chk("bufp", 16'h1E, buf_cur_p);
    chk("bufn", 16'h1E, buf_cur_n);
    chk("temp", 16'h0, {afe_ctrl.temp.core_diode, afe_ctrl.temp.pin_mode});
    chk("dc", 16'h0, afe_ctrl.dc_coupled);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr_reg(16'h18E6, {1'b0, i[2], 4'h0, i[1:0]});
      chk("core", 16'(i[2]), afe_ctrl.temp.core_diode);
      chk("pin", 16'(i[1:0]), afe_ctrl.temp.pin_mode);
      chk("valid", 16'h1, afe_ctrl.temp.code_valid);
    end
    $display("test temp done");
    foreach (fs_code[i]) begin
      wr_reg(16'h1910, {4'h0, fs_code[i]});
      chk("fs_mv", 16'(fs_mv[i]), afe_ctrl.full_scale_mv);
      chk("fs_valid", 16'h1, afe_ctrl.fs_valid);
    end
    for (int c = 6; c <= 20; c += 2) begin
      wr_reg(16'h1A4C, 8'(c));
      wr_reg(16'h1A4D, 8'(c));
      chk("ua_p", 16'(120 + (c - 6) * 20), buf_ua_p);
      chk("ua_n", 16'(120 + (c - 6) * 20), buf_ua_n);
    end
    $display("test ranges done");
    wr_reg(16'h18E6, 8'h87);
    chk("pin_bad", 16'(REFPIN_HIGHZ), afe_ctrl.temp.pin_mode);
    chk("valid_bad", 16'h0, afe_ctrl.temp.code_valid);
    wr_reg(16'h1910, 8'h05);
    chk("fs_bad", 16'h6A4, afe_ctrl.full_scale_mv);
    chk("fs_valid_bad", 16'h0, afe_ctrl.fs_valid);
    wr_reg(16'h1A4C, 8'h07);
    chk("ua_odd", 16'h0, buf_ua_p);
    rd_reg(16'h18E6, got);
    chk("read_full", 16'h87, got);
    @(posedge clk);
    #1;
    chk("rdata_idle", 16'h0, rdata);
    $display("test awkward done");
    results();
  end
endmodule // analog_front_end_config_regs_test
